// ### memmap_defs.svh
`ifndef MEMMAP_DEFS_SVH
`define MEMMAP_DEFS_SVH
// ---------------------------------------------
// register indexes, byte address is four times
// ---------------------------------------------
`define IDX_UNLOCK 8'hc7
`define IDX_POWER 8'hc4
`define IDX_SIZE 8'hc2
`define IDX_STAT 8'hc8
// ---------------------------------------------
// field and key values
// ---------------------------------------------
`define UNLOCK_KEY1 8'haa
`define UNLOCK_KEY2 8'h55
`define DME_RESET 2'b00
`define DME_EXT 2'b00
`define DME_LOW 2'b01
`define DME_RSV 2'b10
`define DME_SCB 2'b11
`define SRAM_LAST 16'h03ff
`define SCB_ADDR 16'hfffc
`define KB_BOUND 17'h00400
// ---------------------------------------------
// timing: machine cycle length in clocks, the rest in machine cycles
// ---------------------------------------------
`define MC_CLKS 4
`define INT_MC 2
`define EXT_MC 3
`define UNLOCK_WIN_MC 3
`endif

// ### memmap_pkg.sv
package memmap_pkg;
	// data access target
	typedef enum logic [1:0] {
		TGT_EXT = 2'b00,
		TGT_INT = 2'b01,
		TGT_SCB = 2'b10,
		TGT_RSV = 2'b11
	} tgt_t;
	// data access engine state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} acc_t;
	// cpu data request
	typedef struct packed {
		logic valid;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} data_req_t;
	// whole block state
	typedef struct packed {
		logic [1:0] dme;
		logic [2:0] size;
		logic unl_armed;
		logic [3:0] unl_win;
		logic ack;
		logic [31:0] rdat;
		acc_t st;
		logic [3:0] cnt;
		tgt_t tgt;
		logic we;
		logic [7:0] rdata;
		logic done;
		logic rsv;
		logic f_done;
		logic f_ext;
		logic bus;
		logic store_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] p0;
		logic [7:0] p2;
		logic sram_en;
		logic sram_we;
		logic [9:0] sram_addr;
	} state_t;
endpackage

// ### memmap_decoder.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defs.svh"
module memmap_decoder #(
	parameter logic [2:0] MAX_SIZE_CODE = 3'd7
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// cpu fetch and data move
	input wire logic fetch_req_i,
	input wire logic [15:0] fetch_addr_i,
	input wire memmap_pkg::data_req_t data_req_i,
	output logic fetch_done_o,
	output logic fetch_ext_o,
	output logic data_done_o,
	output logic data_reserved_o,
	output logic [7:0] data_rdata_o,
	// on-chip sram and control byte
	input wire logic [7:0] sram_rdata_i,
	input wire logic [7:0] scb_i,
	output logic sram_en_o,
	output logic sram_we_o,
	output logic [9:0] sram_addr_o,
	// expanded bus
	input wire logic [7:0] ext_rdata_i,
	output logic bus_active_o,
	output logic [7:0] port0_o,
	output logic [7:0] port2_o,
	output logic program_store_strobe_n_o,
	output logic rd_n_o,
	output logic wr_n_o
);
	import memmap_pkg::*;

	// ---------------------------------------------
	// constants and checks
	// ---------------------------------------------
	localparam int INT_CLKS = `INT_MC * `MC_CLKS;
	localparam int EXT_CLKS = `EXT_MC * `MC_CLKS;
	localparam logic [3:0] INT_LAST = 4'(INT_CLKS - 1);
	localparam logic [3:0] EXT_LAST = 4'(EXT_CLKS - 1);
	localparam logic [3:0] UNLOCK_WIN = 4'(`UNLOCK_WIN_MC * `MC_CLKS);

	// counters are four bits wide
	if (EXT_CLKS > 16 || INT_CLKS > 16 || `UNLOCK_WIN_MC * `MC_CLKS > 15) begin : g_chk
		$error("memmap_decoder: timing counts exceed counter width");
	end

	// ---------------------------------------------
	// decode functions
	// ---------------------------------------------
	// exclusive program limit for a size code
	function automatic logic [16:0] prog_limit(input logic [2:0] code);
		if (code == 3'd0) begin
			prog_limit = 17'h0;
		end else begin
			prog_limit = `KB_BOUND << (code - 3'd1);
		end
	endfunction

	// data address target for an enable code
	function automatic tgt_t data_tgt(input logic [1:0] dme, input logic [15:0] a);
		unique case (dme)
			`DME_EXT: data_tgt = TGT_EXT;
			`DME_LOW: data_tgt = (a <= `SRAM_LAST) ? TGT_INT : TGT_EXT;
			`DME_RSV: data_tgt = TGT_RSV;
			`DME_SCB: begin
				if (a <= `SRAM_LAST) begin
					data_tgt = TGT_INT;
				end else if (a == `SCB_ADDR) begin
					data_tgt = TGT_SCB;
				end else begin
					data_tgt = TGT_RSV;
				end
			end
		endcase
	endfunction

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	state_t s_reg; // registered state
	state_t s_next; // next state
	logic wb_req; // fresh bus request
	logic wb_wr; // write with low lane
	logic [7:0] idx; // register index
	logic f_ext_now; // fetch decode
	tgt_t d_tgt; // data decode
	logic [2:0] size_wr; // clamped size write

	always_comb begin
		idx = adr_i[9:2];
		wb_req = cyc_i && stb_i && !s_reg.ack;
		wb_wr = wb_req && we_i && sel_i[0];
		f_ext_now = {1'b0, fetch_addr_i} >= prog_limit(s_reg.size);
		d_tgt = data_tgt(s_reg.dme, data_req_i.addr);
		size_wr = (dat_i[2:0] > MAX_SIZE_CODE) ? MAX_SIZE_CODE : dat_i[2:0];
	end

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.ack = wb_req;
		s_next.done = 1'b0;
		s_next.f_done = 1'b0;
		// unlock window runs down
		if (s_reg.unl_win != 4'h0) begin
			s_next.unl_win = s_reg.unl_win - 4'h1;
		end
		// register writes
		if (wb_wr) begin
			unique case (idx)
				`IDX_UNLOCK: begin
					// key sequence, any other value disarms
					s_next.unl_armed = (dat_i[7:0] == `UNLOCK_KEY1);
					if (s_reg.unl_armed && dat_i[7:0] == `UNLOCK_KEY2) begin
						s_next.unl_win = UNLOCK_WIN;
					end
				end
				`IDX_POWER: s_next.dme = dat_i[1:0];
				`IDX_SIZE: begin
					if (s_reg.unl_win != 4'h0) begin
						s_next.size = size_wr;
						s_next.unl_win = 4'h0;
					end
				end
				default: ;
			endcase
		end
		// register reads, unmapped reads zero
		s_next.rdat = 32'h0;
		if (wb_req && !we_i) begin
			unique case (idx)
				`IDX_POWER: s_next.rdat = {30'h0, s_reg.dme};
				`IDX_SIZE: s_next.rdat = {29'h0, s_reg.size};
				`IDX_STAT: s_next.rdat = {24'h0, s_reg.f_ext, s_reg.rsv, s_reg.bus,
					s_reg.unl_armed, s_reg.unl_win};
				default: s_next.rdat = 32'h0;
			endcase
		end
		// fetch strobe lasts one clock
		s_next.store_n = 1'b1;
		unique case (s_reg.st)
			ST_IDLE: begin
				s_next.bus = 1'b0;
				s_next.rd_n = 1'b1;
				s_next.wr_n = 1'b1;
				s_next.sram_en = 1'b0;
				s_next.sram_we = 1'b0;
				if (data_req_i.valid) begin
					// data access has priority over fetch
					s_next.tgt = d_tgt;
					s_next.we = data_req_i.we;
					s_next.cnt = 4'h0;
					if (d_tgt == TGT_RSV) begin
						// reserved: answer at once, no access
						s_next.done = 1'b1;
						s_next.rsv = 1'b1;
						s_next.rdata = 8'h0;
					end else begin
						s_next.st = ST_BUSY;
						s_next.rsv = 1'b0;
						if (d_tgt == TGT_INT) begin
							s_next.sram_en = 1'b1;
							s_next.sram_we = data_req_i.we;
							s_next.sram_addr = data_req_i.addr[9:0];
							s_next.p0 = data_req_i.wdata;
						end else if (d_tgt == TGT_EXT) begin
							s_next.bus = 1'b1;
							s_next.p0 = data_req_i.addr[7:0];
							s_next.p2 = data_req_i.addr[15:8];
						end
					end
				end else if (fetch_req_i) begin
					s_next.f_done = 1'b1;
					s_next.f_ext = f_ext_now;
					if (f_ext_now) begin
						s_next.bus = 1'b1;
						s_next.store_n = 1'b0;
						s_next.p0 = fetch_addr_i[7:0];
						s_next.p2 = fetch_addr_i[15:8];
					end
				end
			end
			ST_BUSY: begin
				s_next.cnt = s_reg.cnt + 4'h1;
				s_next.sram_we = 1'b0;
				if (s_reg.tgt == TGT_EXT && s_reg.cnt == 4'h0) begin
					// address phase over, strobe the bus
					s_next.rd_n = s_reg.we;
					s_next.wr_n = !s_reg.we;
				end
				if ((s_reg.tgt == TGT_EXT && s_reg.cnt == EXT_LAST) ||
					(s_reg.tgt != TGT_EXT && s_reg.cnt == INT_LAST)) begin
					s_next.st = ST_IDLE;
					s_next.done = 1'b1;
					s_next.bus = 1'b0;
					s_next.rd_n = 1'b1;
					s_next.wr_n = 1'b1;
					s_next.sram_en = 1'b0;
					unique case (s_reg.tgt)
						TGT_INT: s_next.rdata = sram_rdata_i;
						TGT_SCB: s_next.rdata = scb_i;
						default: s_next.rdata = ext_rdata_i;
					endcase
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
	end

	// ---------------------------------------------
	// state register
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.dme <= `DME_RESET;
			s_reg.size <= MAX_SIZE_CODE;
			s_reg.st <= ST_IDLE;
			s_reg.tgt <= TGT_EXT;
			s_reg.store_n <= 1'b1;
			s_reg.rd_n <= 1'b1;
			s_reg.wr_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign dat_o = s_reg.rdat;
	assign ack_o = s_reg.ack;
	assign fetch_done_o = s_reg.f_done;
	assign fetch_ext_o = s_reg.f_ext;
	assign data_done_o = s_reg.done;
	assign data_reserved_o = s_reg.rsv;
	assign data_rdata_o = s_reg.rdata;
	assign sram_en_o = s_reg.sram_en;
	assign sram_we_o = s_reg.sram_we;
	assign sram_addr_o = s_reg.sram_addr;
	assign bus_active_o = s_reg.bus;
	assign port0_o = s_reg.p0;
	assign port2_o = s_reg.p2;
	assign program_store_strobe_n_o = s_reg.store_n;
	assign rd_n_o = s_reg.rd_n;
	assign wr_n_o = s_reg.wr_n;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	localparam int INT_DLY = INT_CLKS;
	logic idle_fetch; // fetch taken this cycle
	assign idle_fetch = s_reg.st == ST_IDLE && !data_req_i.valid && fetch_req_i;

	property p_fetch_int;
		@(posedge clk_i) disable iff (rst_i)
		idle_fetch && ({1'b0, fetch_addr_i} < prog_limit(s_reg.size)) |=> !fetch_ext_o;
	endproperty
	a_fetch_int: assert property (p_fetch_int) else $error("on-chip fetch went out");

	property p_fetch_ext;
		@(posedge clk_i) disable iff (rst_i)
		idle_fetch && ({1'b0, fetch_addr_i} >= prog_limit(s_reg.size))
			|=> fetch_ext_o && !program_store_strobe_n_o && {port2_o, port0_o} == $past(fetch_addr_i);
	endproperty
	a_fetch_ext: assert property (p_fetch_ext) else $error("external fetch missing");

	property p_strobe;
		@(posedge clk_i) disable iff (rst_i)
		!program_store_strobe_n_o |-> bus_active_o && fetch_ext_o && fetch_done_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe without external fetch");

	property p_dme_off;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.st == ST_IDLE && data_req_i.valid && s_reg.dme == `DME_EXT
			|=> bus_active_o && !sram_en_o;
	endproperty
	a_dme_off: assert property (p_dme_off) else $error("data not external");

	property p_dme_low;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.st == ST_IDLE && data_req_i.valid && s_reg.dme == `DME_LOW
			&& data_req_i.addr <= `SRAM_LAST |=> sram_en_o && !bus_active_o;
	endproperty
	a_dme_low: assert property (p_dme_low) else $error("low data not on-chip");

	property p_int_time;
		@(posedge clk_i) disable iff (rst_i)
		$rose(sram_en_o) |-> !data_done_o [*8] ##1 data_done_o;
	endproperty
	a_int_time: assert property (p_int_time) else $error("on-chip access not two cycles");

	property p_size_lock;
		@(posedge clk_i) disable iff (rst_i)
		$changed(s_reg.size) |-> $past(s_reg.unl_win) != 4'h0;
	endproperty
	a_size_lock: assert property (p_size_lock) else $error("size changed while locked");

	property p_reset_vals;
		@(posedge clk_i)
		$past(rst_i) && !rst_i |-> s_reg.dme == `DME_RESET && s_reg.size == MAX_SIZE_CODE;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_ports_free;
		@(posedge clk_i) disable iff (rst_i)
		bus_active_o |-> !program_store_strobe_n_o || (s_reg.st == ST_BUSY && s_reg.tgt == TGT_EXT);
	endproperty
	a_ports_free: assert property (p_ports_free) else $error("bus active without need");

	property p_rsv;
		@(posedge clk_i) disable iff (rst_i)
		s_reg.st == ST_IDLE && data_req_i.valid && s_reg.dme == `DME_RSV
			|=> data_done_o && data_reserved_o && !bus_active_o;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code accessed memory");

	property p_int_dly;
		@(posedge clk_i) disable iff (rst_i)
		$rose(sram_en_o) |-> ##INT_DLY !sram_en_o;
	endproperty
	a_int_dly: assert property (p_int_dly) else $error("sram enable length wrong");
endmodule // memmap_decoder
`default_nettype wire

// ### ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// memory on the expanded bus
// ------------------------------
module ext_mem (
	// clock
	input wire logic clk_i,
	// bus from the decoder
	input wire logic bus_i,
	input wire logic [7:0] p0_i,
	input wire logic [7:0] p2_i,
	input wire logic rd_n_i,
	// read data
	output logic [7:0] rdata_o
);
	logic [15:0] adr_reg; // latched address
	logic [7:0] last_reg; // last value shown
	// latch the address while the read strobe is idle
	always_ff @(posedge clk_i) begin
		// ports are only looked at while the bus owns them
		if (bus_i && rd_n_i) begin
			adr_reg <= {p2_i, p0_i};
		end
		last_reg <= rdata_o;
	end
	// data only under the strobe, a toggling value otherwise
	always_comb begin
		if (!rd_n_i) begin
			rdata_o = adr_reg[7:0] ^ adr_reg[15:8] ^ 8'h5a;
		end else begin
			rdata_o = ~last_reg;
		end
	end
endmodule // ext_mem
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defs.svh"
module tb;
	import memmap_pkg::*;
	// ------------------------------
	// signals
	// ------------------------------
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0] adr_i = '0;
	logic [3:0] sel_i = '0;
	logic [31:0] dat_i = '0, dat_o;
	logic ack_o, fetch_req_i = 0, fetch_done_o, fetch_ext_o;
	logic [15:0] fetch_addr_i = '0;
	data_req_t data_req_i = '0;
	logic data_done_o, data_reserved_o, sram_en_o, sram_we_o, bus_active_o;
	logic program_store_strobe_n_o, rd_n_o, wr_n_o;
	logic [7:0] data_rdata_o, port0_o, port2_o, rq;
	logic [7:0] scb_i = 8'h3c; // control byte seen at address fffc
	logic [9:0] sram_addr_o;
	wire logic [7:0] sram_rdata_i, ext_rdata_i;
	logic [7:0] sram [1024]; // on-chip data sram
	logic [16:0] lim;
	int num_errors = 0, samples_checked = 0, cycles = 0;
	// ------------------------------
	// design, sram and far side
	// ------------------------------
	memmap_decoder dut (.*);
	ext_mem mem (.clk_i(clk_i), .bus_i(bus_active_o), .p0_i(port0_o), .p2_i(port2_o),
		.rd_n_i(rd_n_o), .rdata_o(ext_rdata_i));
	assign sram_rdata_i = sram[sram_addr_o];
	// sram write port
	always @(posedge clk_i) begin
		if (sram_en_o && sram_we_o) sram[sram_addr_o] <= port0_o;
	end
	// clock and hang guard
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test();
		end
	end
	// ------------------------------
	// tasks
	// ------------------------------
	function automatic logic [7:0] xp(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic wishbone cycle; outputs read right at an edge still hold
	// what the design registered one edge earlier, so ack is seen as sampled
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		// hold the request until ack is sampled high; the hang guard ends a stall
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// one data move; ce counts clocks from the taking edge to the edge that
	// registers done, zero for a reserved place that is answered at once
	task automatic dacc(input logic w, input logic [15:0] a, input logic [7:0] d,
		input int ce, input logic ext, input logic [7:0] re);
		int n;
		logic bs, ss;
		n = 0;
		bs = 1'b0;
		ss = 1'b0;
		@(posedge clk_i);
		data_req_i <= '{1'b1, w, a, d};
		// the design takes the request at this edge
		@(posedge clk_i);
		data_req_i.valid <= 1'b0;
		@(posedge clk_i);
		while (data_done_o !== 1'b1) begin
			bs |= bus_active_o;
			ss |= !(w ? wr_n_o : rd_n_o);
			@(posedge clk_i);
			n++;
		end
		chk("data clocks", 16'(ce), 16'(n));
		chk("bus use", ext, bs);
		chk("strobe", ext, ss);
		chk("reserved", ce == 0, data_reserved_o);
		if (!w) chk("read data", re, data_rdata_o);
	endtask
	// one fetch; the answer stands for the single clock after the taking edge
	task automatic fetch(input logic [15:0] a, input logic ext);
		int n;
		n = 0;
		@(posedge clk_i);
		fetch_req_i <= 1'b1;
		fetch_addr_i <= a;
		// the design takes the request at this edge
		@(posedge clk_i);
		fetch_req_i <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (fetch_done_o !== 1'b1);
		chk("fetch clocks", 1, 16'(n));
		chk("fetch ext", ext, fetch_ext_o);
		chk("store strobe", !ext, program_store_strobe_n_o);
		chk("fetch bus", ext, bus_active_o);
		if (ext) chk("fetch addr", a, {port2_o, port0_o});
	endtask
	// size change with optional unlock, then two machine cycles idle
	task automatic set_size(input logic [2:0] c, input logic unl);
		if (unl) begin
			wb(1'b1, `IDX_UNLOCK, `UNLOCK_KEY1, rq);
			wb(1'b1, `IDX_UNLOCK, `UNLOCK_KEY2, rq);
		end
		// no fetch runs while the map changes, so no vector is taken mid-change
		wb(1'b1, `IDX_SIZE, {5'h0, c}, rq);
		repeat (2 * `MC_CLKS) @(posedge clk_i);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------------------------------
	// test sequence
	// ------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, unlock arming and an unmapped place
		wb(1'b0, `IDX_POWER, 8'h0, rq);
		chk("power reset", 0, rq);
		wb(1'b0, `IDX_SIZE, 8'h0, rq);
		chk("size reset", 7, rq[2:0]);
		wb(1'b1, `IDX_UNLOCK, `UNLOCK_KEY1, rq);
		wb(1'b0, `IDX_STAT, 8'h0, rq);
		chk("unlock armed", 16'h0010, rq);
		wb(1'b1, 8'h10, 8'hff, rq);
		wb(1'b0, 8'h10, 8'h0, rq);
		chk("unmapped", 0, rq);
		$display("test registers done");
		// enables 00: everything external
		dacc(1'b0, 16'h0000, 8'h0, 12, 1'b1, xp(16'h0000));
		dacc(1'b0, 16'hffff, 8'h0, 12, 1'b1, xp(16'hffff));
		// enables 01: low 1k on chip, writes above it go out
		wb(1'b1, `IDX_POWER, {6'h0, `DME_LOW}, rq);
		dacc(1'b1, 16'h0000, 8'ha1, 8, 1'b0, 8'h0);
		dacc(1'b1, 16'h03ff, 8'hb2, 8, 1'b0, 8'h0);
		dacc(1'b0, 16'h03ff, 8'h0, 8, 1'b0, 8'hb2);
		dacc(1'b0, 16'h0400, 8'h0, 12, 1'b1, xp(16'h0400));
		dacc(1'b1, 16'h0400, 8'h77, 12, 1'b1, 8'h0);
		// enables 11 and 10: control byte and reserved, then 00 and 01 again
		wb(1'b1, `IDX_POWER, {6'h0, `DME_SCB}, rq);
		dacc(1'b0, 16'hfffc, 8'h0, 8, 1'b0, 8'h3c);
		dacc(1'b0, 16'h0400, 8'h0, 0, 1'b0, 8'h0);
		dacc(1'b0, 16'hfffd, 8'h0, 0, 1'b0, 8'h0);
		dacc(1'b0, 16'h0000, 8'h0, 8, 1'b0, 8'ha1);
		wb(1'b1, `IDX_POWER, {6'h0, `DME_RSV}, rq);
		dacc(1'b0, 16'h0000, 8'h0, 0, 1'b0, 8'h0);
		wb(1'b1, `IDX_POWER, 8'h0, rq);
		dacc(1'b0, 16'h03ff, 8'h0, 12, 1'b1, xp(16'h03ff));
		wb(1'b1, `IDX_POWER, {6'h0, `DME_LOW}, rq);
		dacc(1'b0, 16'h03ff, 8'h0, 8, 1'b0, 8'hb2);
		$display("test data map done");
		// program size codes
		fetch(16'hffff, 1'b0);
		set_size(3'd1, 1'b0);
		fetch(16'h0400, 1'b0);
		for (int c = 1; c < 8; c++) begin
			set_size(3'(c), 1'b1);
			lim = 17'h00400 << (c - 1);
			fetch(16'(lim - 17'h1), 1'b0);
			if (c < 7) fetch(lim[15:0], 1'b1);
		end
		set_size(3'd0, 1'b1);
		fetch(16'h0000, 1'b1);
		$display("test program map done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
